// ==== rtl/accel_selftest_config_regs.sv ====
// configuration register bank for self-test, range, wire mode and active mode
// assumes the serial front end presents decoded register reads and writes,
// one-cycle strobes synchronous to core_clk_i
// the boot strap is looked at only while reset_i is high
//
// Summary of operation
// - reset, soft reset, hibernate exit restore defaults
// - reads always; writes only while in standby, except soft reset and the mode bit
// - sensor config bit layout; zero reset, boot grounded
// - axis field 00 off, then x, y, z
// - direction bit 0 positive, 1 negative
// - wire mode bit 0 four-wire, 1 three-wire
// - wire mode matters only when spi selected
// - three-wire: data pin bidirectional, output pin floats
// - four-wire after reset and hibernate exit
// - range field selects 2, 4, 8, 16 g
// - scaling 1024, 512, 256, 128 counts per g
`timescale 1ns/1ps
`default_nettype none
module accel_selftest_config_regs (
  // clock and reset
  input  wire logic          core_clk_i,
  input  wire logic          reset_i,
  // board straps and power events
  input  wire logic          interface_choice_pin_i,
  input  wire logic          boot_behaviour_pin_i,
  input  wire logic          hibernate_exit_i,
  // register access from the serial front end
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic          reg_wr_i,
  input  wire logic [7:0]    reg_wdata_i,
  input  wire logic          reg_rd_i,
  output logic [7:0]         reg_rdata_o,
  output logic               reg_rvalid_o,
  output logic               reg_wr_refused_o,
  // serial engine data path
  input  wire logic          serial_out_data_i,
  input  wire logic          serial_out_en_i,
  output logic               serial_in_data_o,
  // serial pins
  input  wire logic          data_pin_i,
  output logic               data_pin_o,
  output logic               data_pin_oe_o,
  input  wire logic          addr_or_serial_out_pin_i,
  output logic               addr_or_serial_out_pin_o,
  output logic               addr_or_serial_out_pin_oe_o,
  // decoded configuration toward the sensor core
  output logic               active_o,
  output logic               selftest_enable_o,
  output logic [2:0]         selftest_axis_onehot_o,
  output logic               selftest_direction_o,
  output logic               three_wire_o,
  output logic [1:0]         range_select_o,
  output logic [10:0]        lsb_per_g_o,
  output logic [7:0]         interrupt_output_config_o,
  output logic [7:0]         interrupt_output_enable_o,
  output logic [7:0]         selftest_idle_duration_o,
  output logic [7:0]         selftest_decimation_o
);
  import accel_cfg_pkg::*;

  // whole state of the bank
  typedef struct packed {
    logic [7:0]  boot_default;   // sensor config reset value chosen by strap
    logic [7:0]  sensor_config_one;
    // interrupt and self-test timing registers
    logic [7:0]  int_out_cfg;
    logic [7:0]  int_out_en;
    logic [7:0]  idle_dur;
    logic [7:0]  decim;
    // read answer and write refusal strobe
    logic [7:0]  rdata;
    logic        rvalid;
    logic        refused;
    // decoded views, registered with the config byte
    logic [2:0]  axis_onehot;
    logic        st_en;
    logic [10:0] scale;
  } state_s;

  state_s st_q;  // registered state
  state_s st_d;  // next state

  // steering bundle between the bank and its pin mux
  serial_pins_if pins ();

  // helpers of the next-state logic
  logic        standby;       // device not active
  logic        restore;       // return to defaults this cycle
  logic [7:0]  cfg_next;      // sensor config after a write or restore
  logic [1:0]  axis_f;        // axis field of cfg_next
  logic [1:0]  range_f;       // range field of cfg_next

  // scale lookup for a range code
  // the default branch covers codes that cannot occur
  function automatic logic [10:0] scale_of(input logic [1:0] code);
    logic [10:0] s;
    s = SCALE_2G;
    case (range_select_e'(code))
      RANGE_2G:  s = SCALE_2G;
      RANGE_4G:  s = SCALE_4G;
      RANGE_8G:  s = SCALE_8G;
      RANGE_16G: s = SCALE_16G;
      default:   s = SCALE_2G;
    endcase
    return s;
  endfunction : scale_of

  // next-state logic
  always_comb begin
    // hold everything unless a branch below changes it
    st_d     = st_q;
    standby  = ~st_q.sensor_config_one[ACTIVE_BIT];
    restore  = 1'b0;
    cfg_next = st_q.sensor_config_one;
    // answer strobes last one cycle only
    st_d.rvalid  = 1'b0;
    st_d.refused = 1'b0;

    // writes to the bank
    if (reg_wr_i) begin
      // each mapped register has its own branch
      case (reg_addr_i)
        // sensor config: soft reset first, then the standby rule
        SENSOR_CONFIG_ONE_ADDR: begin
          if (reg_wdata_i[SOFT_RESET_BIT]) begin
            // soft reset discards every programmed setting
            restore = 1'b1;
          end else if (standby) begin
            // standby: the whole byte is taken
            cfg_next = reg_wdata_i;
          end else begin
            // while active only the mode bit may change, to allow standby
            cfg_next[ACTIVE_BIT] = reg_wdata_i[ACTIVE_BIT];
            st_d.refused = 1'b1;
          end
        end
        // interrupt pin polarity and driver settings
        INTERRUPT_OUTPUT_CONFIG_ADDR: begin
          if (standby) begin
            st_d.int_out_cfg = reg_wdata_i;
          end else begin
            st_d.refused = 1'b1;
          end
        end
        // interrupt output enables
        INTERRUPT_OUTPUT_ENABLE_ADDR: begin
          if (standby) begin
            st_d.int_out_en = reg_wdata_i;
          end else begin
            st_d.refused = 1'b1;
          end
        end
        // self-test idle phase length
        SELFTEST_IDLE_DURATION_ADDR: begin
          if (standby) begin
            st_d.idle_dur = reg_wdata_i;
          end else begin
            st_d.refused = 1'b1;
          end
        end
        // self-test measurement decimation
        SELFTEST_DECIMATION_ADDR: begin
          if (standby) begin
            st_d.decim = reg_wdata_i;
          end else begin
            st_d.refused = 1'b1;
          end
        end
        default: begin
          // unmapped address: write ignored
        end
      endcase
    end

    // leaving hibernate restores defaults as well
    // placed after the write decode so it beats a same-cycle write
    if (hibernate_exit_i) begin
      restore = 1'b1;
    end

    // one place restores every register, whatever asked for it
    if (restore) begin
      // defaults, which also give four-wire spi
      cfg_next         = st_q.boot_default;
      st_d.int_out_cfg = INTERRUPT_OUTPUT_CONFIG_RST;
      st_d.int_out_en  = INTERRUPT_OUTPUT_ENABLE_RST;
      st_d.idle_dur    = SELFTEST_IDLE_DURATION_RST;
      st_d.decim       = SELFTEST_DECIMATION_RST;
      // a restore is never reported as a refusal
      st_d.refused     = 1'b0;
    end

    // soft reset bit never stays set
    cfg_next[SOFT_RESET_BIT] = 1'b0;
    st_d.sensor_config_one   = cfg_next;

    // decoded views of the new configuration
    // decode from the next value so the views match the byte
    axis_f  = cfg_next[AXIS_CHOICE_MSB:AXIS_CHOICE_LSB];
    range_f = cfg_next[RANGE_MSB:RANGE_LSB];
    case (selftest_axis_e'(axis_f))
      AXIS_OFF: st_d.axis_onehot = 3'h0;
      AXIS_X:   st_d.axis_onehot = 3'h1;
      AXIS_Y:   st_d.axis_onehot = 3'h2;
      AXIS_Z:   st_d.axis_onehot = 3'h4;
      default:  st_d.axis_onehot = 3'h0;
    endcase
    // self-test runs whenever an axis is chosen
    st_d.st_en = (axis_f != 2'h0);
    // counts per g follow the range field
    st_d.scale = scale_of(range_f);

    // reads are always served; unmapped reads return zero
    if (reg_rd_i) begin
      st_d.rvalid = 1'b1;
      // the read returns the value before any same-cycle write
      case (reg_addr_i)
        // every register reads back as stored
        SENSOR_CONFIG_ONE_ADDR:       st_d.rdata = st_q.sensor_config_one;
        INTERRUPT_OUTPUT_CONFIG_ADDR: st_d.rdata = st_q.int_out_cfg;
        INTERRUPT_OUTPUT_ENABLE_ADDR: st_d.rdata = st_q.int_out_en;
        SELFTEST_IDLE_DURATION_ADDR:  st_d.rdata = st_q.idle_dur;
        SELFTEST_DECIMATION_ADDR:     st_d.rdata = st_q.decim;
        // unmapped addresses read as zero
        default:                      st_d.rdata = 8'h00;
      endcase
    end
  end

  // state register; strap picks the sensor config default during reset
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st_q.boot_default <= boot_behaviour_pin_i ? SENSOR_CONFIG_ONE_RST_HIGH
                                                : SENSOR_CONFIG_ONE_RST_GND;
      st_q.sensor_config_one <= boot_behaviour_pin_i ? SENSOR_CONFIG_ONE_RST_HIGH
                                                     : SENSOR_CONFIG_ONE_RST_GND;
      // remaining registers take their fixed defaults
      st_q.int_out_cfg <= INTERRUPT_OUTPUT_CONFIG_RST;
      st_q.int_out_en  <= INTERRUPT_OUTPUT_ENABLE_RST;
      st_q.idle_dur    <= SELFTEST_IDLE_DURATION_RST;
      st_q.decim       <= SELFTEST_DECIMATION_RST;
      // no read answer pending after reset
      st_q.rdata       <= 8'h00;
      st_q.rvalid      <= 1'b0;
      st_q.refused     <= 1'b0;
      st_q.axis_onehot <= 3'h0;
      st_q.st_en       <= 1'b0;
      st_q.scale       <= SCALE_2G;
    end else begin
      // every other cycle the whole struct moves at once
      st_q <= st_d;
    end
  end

  // steering toward the pin mux
  // wire mode reaches the mux only through three_wire
  assign pins.spi_selected = interface_choice_pin_i;
  assign pins.three_wire   = st_q.sensor_config_one[WIRE_MODE_BIT];
  // the serial engine's bit and drive request pass straight through
  assign pins.out_data     = serial_out_data_i;
  assign pins.out_en       = serial_out_en_i;
  assign serial_in_data_o  = pins.in_data;

  // pin mux
  // three-wire turnaround and i2c open drain are handled inside
  serial_pin_mux u_pin_mux (
    .ctl                         (pins.mux),
    .data_pin_i                  (data_pin_i),
    .data_pin_o                  (data_pin_o),
    .data_pin_oe_o               (data_pin_oe_o),
    .addr_or_serial_out_pin_i    (addr_or_serial_out_pin_i),
    .addr_or_serial_out_pin_o    (addr_or_serial_out_pin_o),
    .addr_or_serial_out_pin_oe_o (addr_or_serial_out_pin_oe_o)
  );

  // register outputs
  // read port
  assign reg_rdata_o               = st_q.rdata;
  assign reg_rvalid_o              = st_q.rvalid;
  assign reg_wr_refused_o          = st_q.refused;
  // mode and self-test controls
  assign active_o                  = st_q.sensor_config_one[ACTIVE_BIT];
  assign selftest_enable_o         = st_q.st_en;
  assign selftest_axis_onehot_o    = st_q.axis_onehot;
  // direction of the self-test displacement
  assign selftest_direction_o      = st_q.sensor_config_one[DIRECTION_BIT];
  assign three_wire_o              = interface_choice_pin_i
                                     & st_q.sensor_config_one[WIRE_MODE_BIT];
  // range and scaling
  assign range_select_o            = st_q.sensor_config_one[RANGE_MSB:RANGE_LSB];
  assign lsb_per_g_o               = st_q.scale;
  // plain register contents
  assign interrupt_output_config_o = st_q.int_out_cfg;
  assign interrupt_output_enable_o = st_q.int_out_en;
  assign selftest_idle_duration_o  = st_q.idle_dur;
  assign selftest_decimation_o     = st_q.decim;

endmodule : accel_selftest_config_regs
`default_nettype wire

// ==== pkg/accel_cfg_pkg.sv ====
// register offsets, field positions, reset values and field encodings for the
// accelerometer configuration register bank
// assumes an 8-bit register address space and 8-bit registers
package accel_cfg_pkg;

  // register offsets
  localparam logic [7:0] SENSOR_CONFIG_ONE_ADDR       = 8'h15;
  localparam logic [7:0] INTERRUPT_OUTPUT_CONFIG_ADDR = 8'h18;
  localparam logic [7:0] INTERRUPT_OUTPUT_ENABLE_ADDR = 8'h20;
  localparam logic [7:0] SELFTEST_IDLE_DURATION_ADDR  = 8'h37;
  localparam logic [7:0] SELFTEST_DECIMATION_ADDR     = 8'h38;

  // sensor_config_one field positions
  localparam int SOFT_RESET_BIT    = 7;
  localparam int AXIS_CHOICE_MSB   = 6;
  localparam int AXIS_CHOICE_LSB   = 5;
  localparam int DIRECTION_BIT     = 4;
  localparam int WIRE_MODE_BIT     = 3;
  localparam int RANGE_MSB         = 2;
  localparam int RANGE_LSB         = 1;
  localparam int ACTIVE_BIT        = 0;

  // values after reset
  localparam logic [7:0] SENSOR_CONFIG_ONE_RST_GND  = 8'h00;
  localparam logic [7:0] SENSOR_CONFIG_ONE_RST_HIGH = 8'h00;
  localparam logic [7:0] INTERRUPT_OUTPUT_CONFIG_RST = 8'h01;
  localparam logic [7:0] INTERRUPT_OUTPUT_ENABLE_RST = 8'h00;
  localparam logic [7:0] SELFTEST_IDLE_DURATION_RST  = 8'h00;
  localparam logic [7:0] SELFTEST_DECIMATION_RST     = 8'h00;

  // output scaling per range, counts per g
  localparam logic [10:0] SCALE_2G  = 11'h400;
  localparam logic [10:0] SCALE_4G  = 11'h200;
  localparam logic [10:0] SCALE_8G  = 11'h100;
  localparam logic [10:0] SCALE_16G = 11'h080;

  // self-test axis choice encoding
  typedef enum logic [1:0] {
    AXIS_OFF,
    AXIS_X,
    AXIS_Y,
    AXIS_Z
  } selftest_axis_e;

  // full-scale range encoding
  typedef enum logic [1:0] {
    RANGE_2G,
    RANGE_4G,
    RANGE_8G,
    RANGE_16G
  } range_select_e;

endpackage : accel_cfg_pkg

// ==== pkg/serial_pins_if.sv ====
// steering signals between the register bank and its serial pin mux
// assumes a single clock domain; all signals are combinational levels
`timescale 1ns/1ps
`default_nettype none
interface serial_pins_if;
  logic spi_selected;   // interface choice pin says spi
  logic three_wire;     // wire mode bit, three-wire when set
  logic out_data;       // serial engine output bit
  logic out_en;         // serial engine wants to drive
  logic in_data;        // serial data seen at the data pin

  // register bank side
  modport core (
    output spi_selected,
    output three_wire,
    output out_data,
    output out_en,
    input  in_data
  );

  // pin mux side
  modport mux (
    input  spi_selected,
    input  three_wire,
    input  out_data,
    input  out_en,
    output in_data
  );
endinterface : serial_pins_if
`default_nettype wire

// ==== rtl/serial_pin_mux.sv ====
// steers the serial data pins between i2c, four-wire spi and three-wire spi
// assumes the serial engine raises out_en only while it owns the bus
`timescale 1ns/1ps
`default_nettype none
module serial_pin_mux (
  // steering from the register bank
  serial_pins_if.mux         ctl,
  // data pin (i2c data / spi input, bidirectional in three-wire)
  input  wire logic          data_pin_i,
  output logic               data_pin_o,
  output logic               data_pin_oe_o,
  // address / spi serial output pin
  input  wire logic          addr_or_serial_out_pin_i,
  output logic               addr_or_serial_out_pin_o,
  output logic               addr_or_serial_out_pin_oe_o
);
  import accel_cfg_pkg::*;

  // pin routing per bus mode
  always_comb begin
    data_pin_o                  = 1'b0;
    data_pin_oe_o               = 1'b0;
    addr_or_serial_out_pin_o    = 1'b0;
    addr_or_serial_out_pin_oe_o = 1'b0;
    ctl.in_data                 = data_pin_i;
    if (!ctl.spi_selected) begin
      // i2c: open drain, only pull low; wire mode bit ignored
      data_pin_oe_o = ctl.out_en & ~ctl.out_data;
    end else if (ctl.three_wire) begin
      // three-wire: data pin turns around, output pin floats
      data_pin_o    = ctl.out_data;
      data_pin_oe_o = ctl.out_en;
    end else begin
      // four-wire: data leaves on the dedicated output pin
      addr_or_serial_out_pin_o    = ctl.out_data;
      addr_or_serial_out_pin_oe_o = ctl.out_en;
    end
    // addr_or_serial_out_pin_i is the address strap in i2c; sampled elsewhere
  end

endmodule : serial_pin_mux
`default_nettype wire

// ==== sim/accel_cfg_sva.sv ====
// assertions on the ports of the configuration register bank
// assumes a bind onto accel_selftest_config_regs, one clock domain
`timescale 1ns/1ps
`default_nettype none
module accel_cfg_sva (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  // straps, power events and register port
  input wire logic        interface_choice_pin_i,
  input wire logic        hibernate_exit_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_rvalid_o,
  input wire logic        reg_wr_refused_o,
  // decoded configuration and pins
  input wire logic        active_o,
  input wire logic        selftest_enable_o,
  input wire logic [2:0]  selftest_axis_onehot_o,
  input wire logic        selftest_direction_o,
  input wire logic        three_wire_o,
  input wire logic [1:0]  range_select_o,
  input wire logic [10:0] lsb_per_g_o,
  input wire logic [7:0]  interrupt_output_config_o,
  input wire logic        addr_or_serial_out_pin_oe_o
);
  import accel_cfg_pkg::*;
  // one clock and one reset for every property
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic       cfg_wr; // write to the config register, not overridden by hibernate exit
  logic [7:0] wd_q;   // write data of the previous cycle
  assign cfg_wr = reg_wr_i && reg_addr_i == SENSOR_CONFIG_ONE_ADDR && !hibernate_exit_i;
  // keep last write data for the field checks
  always_ff @(posedge core_clk_i) begin
    wd_q <= reg_wdata_i;
  end
  AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered one cycle later");
  AST_REFUSE: assert property (reg_wr_i && active_o && !hibernate_exit_i
    && reg_addr_i == INTERRUPT_OUTPUT_CONFIG_ADDR |=> reg_wr_refused_o
    && $stable(interrupt_output_config_o)) else $error("active write not refused");
  AST_RESET_DEFAULTS: assert property ($fell(reset_i) |-> !active_o && !three_wire_o
    && lsb_per_g_o == SCALE_2G && interrupt_output_config_o == INTERRUPT_OUTPUT_CONFIG_RST)
    else $error("defaults missing after reset");
  AST_SOFT_RESET: assert property (cfg_wr && reg_wdata_i[SOFT_RESET_BIT] |=> !active_o
    && range_select_o == RANGE_2G && interrupt_output_config_o == INTERRUPT_OUTPUT_CONFIG_RST)
    else $error("soft reset did not restore defaults");
  AST_FIELDS: assert property (cfg_wr && !reg_wdata_i[7] && !active_o |=>
    active_o == wd_q[0] && range_select_o == wd_q[2:1] && selftest_direction_o == wd_q[4]
    && selftest_enable_o == (wd_q[6:5] != 2'h0)) else $error("config fields not taken");
  AST_SCALE: assert property (lsb_per_g_o == (SCALE_2G >> range_select_o))
    else $error("scale does not follow range");
  AST_ONEHOT: assert property ($onehot0(selftest_axis_onehot_o)
    && selftest_enable_o == (selftest_axis_onehot_o != 3'h0)) else $error("axis decode bad");
  AST_WIRE_SPI_ONLY: assert property (three_wire_o |-> interface_choice_pin_i)
    else $error("three-wire outside spi");
  AST_OUT_PIN_FLOATS: assert property (three_wire_o |-> !addr_or_serial_out_pin_oe_o)
    else $error("output pin driven in three-wire");
endmodule : accel_cfg_sva
`default_nettype wire

// ==== sim/host_model.sv ====
// host side model: issues decoded register reads and writes
// assumes the device samples strobes on the rising edge, one access at a time
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic       core_clk_i,
  // register port toward the device
  output logic [7:0]      reg_addr_o,
  output logic            reg_wr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  // idle bus at time zero
  initial begin
    reg_addr_o  = 8'h00;
    reg_wr_o    = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o    = 1'b0;
  end
  // one write strobe across one rising edge; data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    reg_addr_o  = a;
    reg_wdata_o = d;
    reg_wr_o    = 1'b1;
    @(negedge core_clk_i);
    reg_wr_o    = 1'b0;
    reg_wdata_o = ~d;
  endtask : wr
  // one read strobe; the answer stands in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge core_clk_i);
    reg_addr_o = a;
    reg_rd_o   = 1'b1;
    @(negedge core_clk_i);
    reg_rd_o = 1'b0;
    ok       = reg_rvalid_i;
    d        = reg_rdata_i;
  endtask : rd
endmodule : host_model
`default_nettype wire

// ==== sim/accel_selftest_config_regs_test.sv ====
// self-checking bench for the configuration register bank
// assumes host_model drives the register port; pins looped back here
`timescale 1ns/1ps
`default_nettype none
module accel_selftest_config_regs_test;
  import accel_cfg_pkg::*;
  logic core_clk_i, reset_i, intf, hib, sod, soe, tgl, ok;
  logic wr, rd, rvalid, refused, active, three, dout, doe, aoe, din, ao, boot;
  logic [7:0] addr, wdata, rdata, d, ieo, ido, dco;
  logic [2:0] onehot;
  logic [10:0] lsb;
  int n_mismatch, check_count;
  // rows: address, reset value, write value, readback
  logic [7:0] ad[6] = '{8'h15, 8'h18, 8'h20, 8'h37, 8'h38, 8'h40};
  logic [7:0] rs[6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wd[6] = '{8'h5C, 8'hA5, 8'h3C, 8'h12, 8'h05, 8'h77};
  logic [7:0] ex[6] = '{8'h5C, 8'hA5, 8'h3C, 8'h12, 8'h05, 8'h00};
  wire  data_pin = doe ? dout : tgl; // released line shows a changing pattern
  accel_selftest_config_regs dut (.core_clk_i, .reset_i, .interface_choice_pin_i(intf),
    .boot_behaviour_pin_i(boot), .hibernate_exit_i(hib), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .reg_wr_refused_o(refused), .serial_out_data_i(sod),
    .serial_out_en_i(soe), .serial_in_data_o(din), .data_pin_i(data_pin),
    .data_pin_o(dout), .data_pin_oe_o(doe), .addr_or_serial_out_pin_i(1'b0),
    .addr_or_serial_out_pin_o(ao), .addr_or_serial_out_pin_oe_o(aoe), .active_o(active),
    .selftest_enable_o(), .selftest_axis_onehot_o(onehot), .selftest_direction_o(),
    .three_wire_o(three), .range_select_o(), .lsb_per_g_o(lsb),
    .interrupt_output_config_o(), .interrupt_output_enable_o(ieo),
    .selftest_idle_duration_o(ido), .selftest_decimation_o(dco));
  host_model host (.core_clk_i, .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
    .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  // compare and count
  task automatic chk(input logic [10:0] s, input logic [10:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  // verdict and end of run
  task automatic results;
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results
  // clock and pattern on the released data line
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(negedge core_clk_i) tgl <= ~tgl;
  // watchdog
  initial begin
    #100us;
    n_mismatch++;
    results();
  end
  // main sequence
  initial begin
    {reset_i, intf, hib, sod, soe, tgl} = 6'b110000;
    boot = 1'b0;
    repeat (10) @(negedge core_clk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 6; i++) begin
      host.rd(ad[i], d, ok);
      chk(11'(ok), 11'h001);
      chk(11'(d), 11'(rs[i]));
    end
    for (int i = 0; i < 6; i++) begin
      host.wr(ad[i], wd[i]);
      host.rd(ad[i], d, ok);
      chk(11'(d), 11'(ex[i]));
    end
    chk(11'(ieo), 11'h03C);
    chk(11'(ido), 11'h012);
    chk(11'(dco), 11'h005);
    soe = 1'b1;
    sod = 1'b1;
    #1 chk(11'({three, doe, aoe}), 11'h006);
    chk(11'({dout, din}), 11'h003);
    intf = 1'b0;
    #1 chk(11'(three), 11'h000);
    chk(11'(doe), 11'h000);
    chk(11'(din), 11'(tgl));
    intf = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.wr(SENSOR_CONFIG_ONE_ADDR, {1'b0, 2'(i), 2'b00, 2'(i), 1'b0});
      chk(11'(onehot), 11'((4'h1 << i) >> 1));
      chk(lsb, 11'h400 >> i);
    end
    chk(11'({aoe, ao, doe}), 11'h006);
    host.wr(SENSOR_CONFIG_ONE_ADDR, 8'h23);
    host.wr(INTERRUPT_OUTPUT_ENABLE_ADDR, 8'hFF);
    chk(11'(refused), 11'h001);
    host.wr(INTERRUPT_OUTPUT_CONFIG_ADDR, 8'hFF);
    chk(11'(refused), 11'h001);
    host.rd(INTERRUPT_OUTPUT_ENABLE_ADDR, d, ok);
    chk(11'(d), 11'h03C);
    host.wr(SENSOR_CONFIG_ONE_ADDR, 8'h00);
    chk(11'(active), 11'h000);
    host.wr(SENSOR_CONFIG_ONE_ADDR, 8'h80);
    host.rd(INTERRUPT_OUTPUT_CONFIG_ADDR, d, ok);
    chk(11'(d), 11'h001);
    host.wr(SENSOR_CONFIG_ONE_ADDR, 8'h08);
    host.wr(INTERRUPT_OUTPUT_CONFIG_ADDR, 8'h5A);
    @(negedge core_clk_i) hib = 1'b1;
    @(negedge core_clk_i) hib = 1'b0;
    chk(11'(three), 11'h000);
    host.rd(INTERRUPT_OUTPUT_CONFIG_ADDR, d, ok);
    chk(11'(d), 11'h001);
    host.wr(SELFTEST_DECIMATION_ADDR, 8'h05);
    host.wr(SENSOR_CONFIG_ONE_ADDR, 8'h46);
    boot = 1'b1;
    @(negedge core_clk_i) reset_i = 1'b1;
    @(negedge core_clk_i) reset_i = 1'b0;
    host.rd(SELFTEST_DECIMATION_ADDR, d, ok);
    chk(11'(d), 11'h000);
    host.rd(SENSOR_CONFIG_ONE_ADDR, d, ok);
    chk(11'(d), 11'(SENSOR_CONFIG_ONE_RST_HIGH));
    chk(lsb, 11'h400);
    results();
  end
endmodule : accel_selftest_config_regs_test
bind accel_selftest_config_regs accel_cfg_sva sva_i (.core_clk_i, .reset_i,
  .interface_choice_pin_i, .hibernate_exit_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
  .reg_rd_i, .reg_rvalid_o, .reg_wr_refused_o, .active_o, .selftest_enable_o,
  .selftest_axis_onehot_o, .selftest_direction_o, .three_wire_o, .range_select_o,
  .lsb_per_g_o, .interrupt_output_config_o, .addr_or_serial_out_pin_oe_o);
`default_nettype wire
